//--- hdl/gbx_serializer.v
// output gearbox serializer of a top-edge io_cell
// assumes clk_i is the bit-rate clock; the slow core clock and core data
// arrive asynchronously and are brought in through two flip-flops
//
// Contract
// [RULE1] 8:1 serializer with 7:1, 8:1, dual 4:1
// [RULE2] 8-bit word; 7:1 low seven, 4:1 nibbles
// [RULE3] first stage captures word on slow clock
// [RULE4] second stage hands word to fast registers
// [RULE5] third stage shifts bits out one by one
// [RULE6] DDR: both edges, bit zero first, clock ratio; edge clock stays high for two bits between back-to-back 7:1 words
`timescale 1ns/1ps
`include "gbx_consts.vh"

module gbx_serializer (
    // clock and reset
    input  wire                   clk_i,
    input  wire                   rst_i,
    // core side, slow domain
    input  wire                   slow_clk_i,
    input  wire [`GBX_WORD_W-1:0] data_i,
    input  wire [1:0]             mode_i,
    // serial outputs to the output buffers
    output reg                    q_o,
    output reg                    q2_o,
    output reg                    fast_edge_clk_o,
    // status
    output reg                    busy_o,
    output reg                    word_taken_o,
    output reg                    underrun_o
);

    localparam ST_IDLE = 2'b01;
    localparam ST_RUN  = 2'b10;

    // input synchronisers
    reg                   slow_s1;
    reg                   slow_s2;
    reg                   slow_s3;
    reg [`GBX_WORD_W-1:0] data_s1;
    reg [`GBX_WORD_W-1:0] data_s2;
    reg [1:0]             mode_s1;
    reg [1:0]             mode_s2;

    // first stage
    reg [`GBX_WORD_W-1:0] cap_word;
    reg                   cap_pend;

    // sequencer
    reg [1:0]             state;
    reg [1:0]             next_state;
    reg [2:0]             bit_cnt;
    reg [2:0]             next_bit_cnt;
    reg [1:0]             run_mode;
    reg [2:0]             last_idx;
    reg                   load;
    reg                   run;
    reg                   starve;

    wire                  slow_rise;
    wire [1:0]            lane_q;
    wire [1:0]            lane_en;
    wire [2*`GBX_WORD_W-1:0] lane_word;
    wire                  out_en;
    wire [`GBX_WORD_W-1:0] word_a;
    wire [`GBX_WORD_W-1:0] word_b;
    wire                  dual_now;
    wire                  dual_run;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            slow_s1 <= 1'b0;
            slow_s2 <= 1'b0;
            slow_s3 <= 1'b0;
            data_s1 <= `GBX_RST_WORD;
            data_s2 <= `GBX_RST_WORD;
            mode_s1 <= `GBX_RST_MODE;
            mode_s2 <= `GBX_RST_MODE;
        end else begin
            slow_s1 <= slow_clk_i;
            slow_s2 <= slow_s1;
            slow_s3 <= slow_s2;
            data_s1 <= data_i;
            data_s2 <= data_s1;
            mode_s1 <= mode_i;
            mode_s2 <= mode_s1;
        end
    end

    assign slow_rise = slow_s2 & ~slow_s3;

    // slow-clock capture; a new capture wins over the clear by a load
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cap_word <= `GBX_RST_WORD;
            cap_pend <= 1'b0;
        end else if (slow_rise) begin
            cap_word <= data_s2; // RULE3
            cap_pend <= 1'b1;
        end else if (load) begin
            cap_pend <= 1'b0;
        end
    end

    // last bit index of the mode in use
    always @* begin
        case (run_mode)
            `GBX_MODE_7TO1: last_idx = `GBX_LAST_7TO1; // RULE1
            `GBX_MODE_DUAL4: last_idx = `GBX_LAST_4TO1; // RULE1
            default: last_idx = `GBX_LAST_8TO1; // RULE1
        endcase
    end

    // sequencer: load a pending word at each word boundary
    always @* begin
        next_state   = state;
        next_bit_cnt = bit_cnt;
        load         = 1'b0;
        run          = 1'b0;
        starve       = 1'b0;
        case (state)
            ST_IDLE: begin
                if (cap_pend) begin
                    load         = 1'b1;
                    next_bit_cnt = `GBX_RST_CNT;
                    next_state   = ST_RUN;
                end
            end
            ST_RUN: begin
                if (bit_cnt == last_idx) begin
                    if (cap_pend) begin
                        load         = 1'b1; // RULE4
                        next_bit_cnt = `GBX_RST_CNT;
                    end else begin
                        starve     = 1'b1;
                        next_state = ST_IDLE;
                    end
                end else begin
                    run          = 1'b1; // RULE5
                    next_bit_cnt = bit_cnt + 3'h1;
                end
            end
            default: begin
                next_state   = ST_IDLE;
                next_bit_cnt = `GBX_RST_CNT;
            end
        endcase
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state    <= ST_IDLE;
            bit_cnt  <= `GBX_RST_CNT;
            run_mode <= `GBX_RST_MODE;
        end else begin
            state   <= next_state;
            bit_cnt <= next_bit_cnt;
            if (load) begin
                run_mode <= mode_s2;
            end
        end
    end

    // word split per mode
    assign dual_now = (mode_s2 == `GBX_MODE_DUAL4);
    assign dual_run = (run_mode == `GBX_MODE_DUAL4);
    assign word_a = dual_now ? {4'h0, cap_word[`GBX_HALF_W-1:0]} : // RULE2
                    (mode_s2 == `GBX_MODE_7TO1) ?
                    {1'b0, cap_word[6:0]} : cap_word; // RULE2
    assign word_b = dual_now ?
                    {4'h0, cap_word[`GBX_WORD_W-1:`GBX_HALF_W]} : // RULE2
                    `GBX_RST_WORD;
    assign out_en = (state == ST_RUN);

    // one shift lane per output; both lanes load and shift in every mode, lane b output only enabled in dual mode
    assign lane_en   = {out_en & dual_run, out_en};
    assign lane_word = {word_b, word_a};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_lane
            gbx_lane u_lane (
                .clk_i    (clk_i),
                .rst_i    (rst_i),
                .load_i   (load),
                .run_i    (run),
                .out_en_i (lane_en[gi]),
                .word_i   (lane_word[gi*`GBX_WORD_W +: `GBX_WORD_W]),
                .q_o      (lane_q[gi])
            );
        end
    endgenerate

    // edge clock out: high on even bits; bit zero reaches q_o on the first fall,
    // and each clk_i rise is one edge of the forwarded clock, except between a 7:1 word and a word of any mode loaded right after it
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fast_edge_clk_o <= 1'b0;
            busy_o          <= 1'b0;
            word_taken_o    <= 1'b0;
            underrun_o      <= 1'b0;
        end else begin
            fast_edge_clk_o <= out_en & ~bit_cnt[0]; // RULE6
            busy_o          <= out_en;
            word_taken_o    <= load;
            underrun_o      <= starve;
        end
    end

    // lanes already end in flip-flops; one more stage puts the bits a clock behind the edge clock
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q_o  <= 1'b0;
            q2_o <= 1'b0;
        end else begin
            q_o  <= lane_q[0]; // RULE5
            q2_o <= lane_q[1]; // RULE5
        end
    end

endmodule // gbx_serializer

//--- hdl/gbx_consts.vh
// gearbox serializer constants: mode codes, bit counts, reset values
// assumes inclusion by bare name from the gearbox design files
`ifndef GBX_CONSTS_VH
`define GBX_CONSTS_VH

// serializer modes on the mode input
`define GBX_MODE_7TO1      2'h0
`define GBX_MODE_8TO1      2'h1
`define GBX_MODE_DUAL4     2'h2

// index of the last bit of a word in each mode
`define GBX_LAST_7TO1      3'h6
`define GBX_LAST_8TO1      3'h7
`define GBX_LAST_4TO1      3'h3

// widths
`define GBX_WORD_W         8
`define GBX_HALF_W         4

// reset values
`define GBX_RST_WORD       8'h00
`define GBX_RST_MODE       2'h1
`define GBX_RST_CNT        3'h0
`define GBX_RST_BIT        1'b0

`endif

//--- hdl/gbx_lane.v
// one shift lane of the output gearbox: word register and output bit
// assumes load and run come from the gearbox sequencer on the same clock
`timescale 1ns/1ps
`include "gbx_consts.vh"

module gbx_lane (
    // clock and reset
    input  wire                   clk_i,
    input  wire                   rst_i,
    // sequencer control
    input  wire                   load_i,
    input  wire                   run_i,
    input  wire                   out_en_i,
    input  wire [`GBX_WORD_W-1:0] word_i,
    // serial output
    output reg                    q_o
);

    reg [`GBX_WORD_W-1:0] shift_word;

    // high-speed register takes the word, then walks it lsb first
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_word <= `GBX_RST_WORD;
        end else if (load_i) begin
            shift_word <= word_i; // RULE4
        end else if (run_i) begin
            shift_word <= {1'b0, shift_word[`GBX_WORD_W-1:1]}; // RULE5
        end
    end

    // output bit register feeding the serializer's q_o or q2_o register
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q_o <= `GBX_RST_BIT;
        end else if (out_en_i) begin
            q_o <= shift_word[0]; // RULE5
        end else begin
            q_o <= 1'b0;
        end
    end

endmodule // gbx_lane

//--- testbench/gbx_serializer_checker.sv
// port checker for the gearbox serializer
// assumes it is bound into the serializer and sees only its ports
`timescale 1ns/1ps
module gbx_serializer_checker (
    input wire       clk_i,
    input wire       rst_i,
    input wire       slow_clk_i,
    input wire [7:0] data_i,
    input wire [1:0] mode_i,
    input wire       q_o,
    input wire       q2_o,
    input wire       fast_edge_clk_o,
    input wire       busy_o,
    input wire       word_taken_o,
    input wire       underrun_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_idle_lane_a: assert property (!busy_o |=> !q_o)
        else $error("lane a active while idle");
    chk_idle_lane_b: assert property (!busy_o |=> !q2_o)
        else $error("lane b active while idle");
    chk_edge_idle: assert property (!busy_o |-> !fast_edge_clk_o)
        else $error("edge clock runs while idle");
    chk_edge_first: assert property ($rose(busy_o) |->
        fast_edge_clk_o ##1 !fast_edge_clk_o)
        else $error("edge clock phase wrong at word start");
    chk_run_length: assert property ($rose(busy_o) |-> busy_o[*4])
        else $error("shift run shorter than four bits");
    chk_taken_pulse: assert property (word_taken_o |=> !word_taken_o)
        else $error("word taken pulse too long");
    chk_taken_busy: assert property (word_taken_o |=> busy_o)
        else $error("word taken without shifting");
    chk_underrun_end: assert property (underrun_o |=> !busy_o)
        else $error("still shifting after underrun");
    chk_slow_taken: assert property ($rose(slow_clk_i) && !busy_o
        |-> ##[2:5] word_taken_o)
        else $error("slow word not taken in time");
    cover property (word_taken_o);
    cover property (underrun_o);
    cover property (q2_o);
endmodule // gbx_serializer_checker

bind gbx_serializer gbx_serializer_checker chk (.clk_i(clk_i),
    .rst_i(rst_i), .slow_clk_i(slow_clk_i), .data_i(data_i),
    .mode_i(mode_i), .q_o(q_o), .q2_o(q2_o),
    .fast_edge_clk_o(fast_edge_clk_o), .busy_o(busy_o),
    .word_taken_o(word_taken_o), .underrun_o(underrun_o));

//--- testbench/gbx_rx_model.sv
// receiving end of the two serial lanes, one bit per clock
// assumes busy leads the lanes by one clock
`timescale 1ns/1ps
module gbx_rx_model (
    input  wire         clk_i,
    input  wire         rst_i,
    input  wire         clr_i,
    input  wire         busy_i,
    input  wire         q_i,
    input  wire         q2_i,
    output logic [15:0] a_o,
    output logic [7:0]  b_o,
    output logic [4:0]  n_o
);
    logic v;
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i || clr_i) begin
            v <= 1'b0;
            n_o <= 5'h00;
            a_o <= 16'h0000;
            b_o <= 8'h00;
        end else begin
            v <= busy_i;
            if (v) begin
                a_o[n_o[3:0]] <= q_i;
                b_o[n_o[2:0]] <= q2_i;
                n_o <= n_o + 5'h01;
            end
        end
    end
endmodule // gbx_rx_model

//--- testbench/gbx_serializer_test.sv
// self-checking bench for the gearbox serializer
// assumes the receiver model and checker beside the design
`timescale 1ns/1ps
`define CHK(n,e,g) begin compares++; if ((g) !== (e)) begin \
    miscompares++; $display("wrong value %s exp %h got %h", n, e, g); end end
module gbx_serializer_test;
    logic clk_i = 0, rst_i = 1, slow_clk_i = 0, clr = 0;
    logic [7:0] data_i = 8'h00, ur = 8'h00, ur0;
    logic [7:0] fc = 8'h00, fc0, tk = 8'h00, tk0;
    logic [1:0] mode_i = 2'h1;
    wire q_o, q2_o, fclk, busy_o, taken, under_o;
    wire [15:0] rxa;
    wire [7:0]  rxb;
    wire [4:0]  rxn;
    int miscompares = 0, compares = 0, cyc = 0;
    always #5 clk_i = ~clk_i;
    gbx_serializer DUT (.clk_i(clk_i), .rst_i(rst_i),
        .slow_clk_i(slow_clk_i), .data_i(data_i), .mode_i(mode_i),
        .q_o(q_o), .q2_o(q2_o), .fast_edge_clk_o(fclk),
        .busy_o(busy_o), .word_taken_o(taken), .underrun_o(under_o));
    gbx_rx_model rx (.clk_i(clk_i), .rst_i(rst_i), .clr_i(clr),
        .busy_i(busy_o), .q_i(q_o), .q2_i(q2_o), .a_o(rxa), .b_o(rxb),
        .n_o(rxn));
    always @(posedge clk_i) begin
        cyc++;
        if (under_o === 1'b1) ur <= ur + 8'h01;
        if (fclk === 1'b1) fc <= fc + 8'h01;
        if (taken === 1'b1) tk <= tk + 8'h01;
        if (cyc == 3000) begin
            miscompares++;
            end_of_test;
        end
    end
    task automatic tick(int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // one slow clock period of 8 fast cycles carrying a word
    task automatic put(logic [7:0] w);
        data_i = w;
        tick(1);
        slow_clk_i = 1'b1;
        tick(4);
        slow_clk_i = 1'b0;
        tick(3);
    endtask
    task automatic start(logic [1:0] m);
        mode_i = m;
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        ur0 = ur;
        fc0 = fc;
        tk0 = tk;
    endtask
    task automatic drain;
        for (int i = 0; i < 40 && busy_o !== 1'b0; i++) tick(1);
        tick(2);
    endtask
    task automatic t_eight(logic [1:0] m);
        start(m);
        put(8'hA5);
        drain;
        `CHK("bits8", 5'h08, rxn)
        `CHK("word8", 8'hA5, rxa[7:0])
        `CHK("laneb8", 8'h00, rxb)
        `CHK("under8", 8'h01, ur - ur0)
        `CHK("edges8", 8'h04, fc - fc0)
    endtask
    task automatic t_seven;
        start(2'h0);
        put(8'hD3);
        drain;
        `CHK("bits7", 5'h07, rxn)
        `CHK("word7", 7'h53, rxa[6:0])
    endtask
    task automatic t_dual;
        start(2'h2);
        put(8'h6C);
        drain;
        `CHK("bits4", 5'h04, rxn)
        `CHK("lanea", 4'hC, rxa[3:0])
        `CHK("laneb", 4'h6, rxb[3:0])
        `CHK("edges4", 8'h02, fc - fc0)
    endtask
    task automatic t_back;
        start(2'h1);
        put(8'h3C);
        put(8'hE1);
        drain;
        `CHK("bits16", 5'h10, rxn)
        `CHK("stream", 16'hE13C, rxa)
        `CHK("under16", 8'h01, ur - ur0)
        `CHK("taken16", 8'h02, tk - tk0)
    endtask
    task automatic end_of_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        tick(20);
        rst_i = 1'b0;
        tick(2);
        `CHK("idle", 6'h00, {q_o, q2_o, fclk, busy_o, taken, under_o})
        t_eight(2'h1);
        t_eight(2'h3);
        t_seven;
        t_dual;
        t_back;
        end_of_test;
    end
endmodule // gbx_serializer_test
